// ### design/pof_regs.svh
// pixel output formatter: register offsets, fields, reset values and constants
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef POF_REGS_SVH
`define POF_REGS_SVH

// register byte offsets
`define POF_OFS_CTRL 8'h00
`define POF_OFS_PATTERN 8'h04
`define POF_OFS_SIZE 8'h08
`define POF_OFS_STATUS 8'h0C

// control register fields
`define POF_CTRL_FMT_LSB 0
`define POF_CTRL_DEPTH_LSB 3
`define POF_CTRL_MIRROR_X 5
`define POF_CTRL_MIRROR_Y 6
`define POF_CTRL_ACQ_EN 7
`define POF_CTRL_PHASE_LSB 8

// pattern register fields
`define POF_PAT_SELECT 0
`define POF_PAT_CHOICE_LSB 1

// size register fields
`define POF_SIZE_W_LSB 0
`define POF_SIZE_H_LSB 16

// status register fields
`define POF_STAT_PHASE_LSB 0
`define POF_STAT_DRAIN 2
`define POF_STAT_FRAMES_LSB 8

// reset values
`define POF_RST_WIDTH 16'h0000
`define POF_RST_HEIGHT 16'h0000

// luma and chroma weights, scaled by 256
`define POF_KY_R 18'sd77
`define POF_KY_G 18'sd150
`define POF_KY_B 18'sd29
`define POF_KB_R (-18'sd43)
`define POF_KB_G (-18'sd85)
`define POF_KB_B 18'sd128
`define POF_KR_R 18'sd128
`define POF_KR_G (-18'sd107)
`define POF_KR_B (-18'sd21)
`define POF_CHROMA_OFS 18'sd128

`endif

// ### design/pof_pkg.sv
// pixel output formatter: shared types
// assumes no other file; its enum codes fit the fields of pof_regs.svh
package pof_pkg;

  // output pixel formats
  typedef enum logic [2:0] {
    FMT_RAW8 = 3'h0,
    FMT_RAW16 = 3'h1,
    FMT_LUMA_CHROMA_444 = 3'h2,
    FMT_LUMA_CHROMA_422 = 3'h3,
    FMT_LUMA_CHROMA_411 = 3'h4
  } pof_fmt_t;

  // converter bit depth
  typedef enum logic [1:0] {DEPTH_10 = 2'h0, DEPTH_12 = 2'h1, DEPTH_14 = 2'h2} pof_depth_t;

  // pattern choices; sensor source knows off and sensor, head source off, increment, varframe
  typedef enum logic [1:0] {PAT_OFF = 2'h0, PAT_SENSOR = 2'h1, PAT_INCREMENT = 2'h2, PAT_VARFRAME = 2'h3} pof_pat_t;

  // mosaic phase: bit 0 is column order, bit 1 is row order
  typedef enum logic [1:0] {
    PH_MOSAIC_RED_GREEN = 2'h0,
    PH_MOSAIC_GREEN_RED = 2'h1,
    PH_MOSAIC_GREEN_BLUE = 2'h2,
    PH_MOSAIC_BLUE_GREEN = 2'h3
  } pof_phase_t;

  // component carried by one output word
  typedef enum logic [1:0] {COMP_RAW, COMP_Y, COMP_CB, COMP_CR} pof_comp_t;

  // incoming pixel: raw converter sample at the low bits, plus interpolated colour
  typedef struct packed {
    logic sof;
    logic [13:0] raw;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pof_in_t;

  // stored pixel: raw left-justified to 16 bits
  typedef struct packed {
    logic [15:0] raw;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pof_pix_t;

  // outgoing 2-byte word with framing marks
  typedef struct packed {
    logic sof;
    logic eol;
    logic [15:0] data;
  } pof_word_t;

endpackage : pof_pkg

// ### design/pof_top.sv
// pixel output formatter: frame store with mirroring, test patterns, colour subsampling
// assumes an AHB-Lite master on hclk and a same-clock pixel source and sink
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pof_regs.svh"

// How it works
// - 4:4:4 emits Cb, Y, Cr every pixel
// - 4:2:2 halves chroma horizontally, all lines kept
// - 4:1:1 quarters chroma horizontally, all lines kept
// - 8-bit components clamp to 0..255
// - narrower format drops low sample bits
// - wider format pads low sample bits
// - samples left-justified in a 16-bit word
// - selector picks source; off disables that source
// - head pattern enters before all processing
// - increment pattern steps per pixel, wraps 255
// - varying frames restart at acquisition start
// - head pattern overrides sensor pattern
// - processing acts on pattern, sensor controls not
// - mirror x reverses pixels in a line
// - mirror y reverses line order
// - mirroring happens before any cropping
// - mirror x swaps mosaic column order
// - mirror y swaps mosaic row order
// - luma and chroma weights, chroma offset 128
module pof_top import pof_pkg::*; #(
  parameter int XW = 6, // log2 of largest line width
  parameter int YW = 5  // log2 of largest frame height
) (
  input wire logic hclk, // bus and pixel clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic in_valid, // incoming pixel valid
  output logic in_ready, // frame store accepts pixel
  input wire pof_in_t in_pix, // incoming pixel
  output logic out_valid, // outgoing word valid
  input wire logic out_ready, // sink takes word
  output pof_word_t out_word, // outgoing word
  output pof_phase_t mosaic_phase // mosaic phase after mirroring
);

  localparam int NPIX = 1 << (XW + YW);

  typedef enum {S_IDLE, S_FILL, S_DRAIN} pof_state_t;

  // left-justify a converter sample into 16 bits, padding low bits
  function automatic logic [15:0] pof_justify(input logic [13:0] s, input pof_depth_t d);
    unique case (d)
      DEPTH_10: pof_justify = {s[9:0], 6'h00};
      DEPTH_12: pof_justify = {s[11:0], 4'h0};
      default: pof_justify = {s[13:0], 2'h0};
    endcase
  endfunction : pof_justify

  // limit a size setting to the store; zero means the largest
  function automatic logic [15:0] pof_lim(input logic [15:0] v, input int w);
    logic [16:0] cap;
    cap = 17'(1 << w);
    if (v == 16'h0000 || {1'b0, v} > cap) pof_lim = cap[15:0];
    else pof_lim = v;
  endfunction : pof_lim

  // clamp a signed sum into an unsigned byte
  function automatic logic [7:0] pof_clamp(input logic signed [17:0] v);
    if (v < 0) pof_clamp = 8'h00;
    else if (v > 18'sd255) pof_clamp = 8'hFF;
    else pof_clamp = v[7:0];
  endfunction : pof_clamp

  // colour conversion of one component
  function automatic logic [7:0] pof_ycc(input pof_comp_t c, input pof_pix_t p);
    logic signed [17:0] sr;
    logic signed [17:0] sg;
    logic signed [17:0] sb;
    logic signed [17:0] acc;
    sr = $signed({10'h000, p.r});
    sg = $signed({10'h000, p.g});
    sb = $signed({10'h000, p.b});
    unique case (c)
      COMP_CB: acc = ((`POF_KB_R * sr + `POF_KB_G * sg + `POF_KB_B * sb) >>> 8) + `POF_CHROMA_OFS;
      COMP_CR: acc = ((`POF_KR_R * sr + `POF_KR_G * sg + `POF_KR_B * sb) >>> 8) + `POF_CHROMA_OFS;
      default: acc = (`POF_KY_R * sr + `POF_KY_G * sg + `POF_KY_B * sb) >>> 8;
    endcase
    pof_ycc = pof_clamp(acc);
  endfunction : pof_ycc

  // words emitted for the pixel at output column x
  function automatic logic [1:0] pof_words(input pof_fmt_t f, input logic [1:0] x);
    unique case (f)
      FMT_LUMA_CHROMA_444: pof_words = 2'd3;
      FMT_LUMA_CHROMA_422: pof_words = 2'd2;
      FMT_LUMA_CHROMA_411: pof_words = x[0] ? 2'd1 : 2'd2;
      default: pof_words = 2'd1;
    endcase
  endfunction : pof_words

  // component of word s of the pixel at output column x
  function automatic pof_comp_t pof_comp(input pof_fmt_t f, input logic [1:0] x, input logic [1:0] s);
    unique case (f)
      FMT_LUMA_CHROMA_444: pof_comp = (s == 2'd0) ? COMP_CB : (s == 2'd1) ? COMP_Y : COMP_CR;
      FMT_LUMA_CHROMA_422: pof_comp = (s == 2'd1) ? COMP_Y : (x[0] ? COMP_CR : COMP_CB);
      FMT_LUMA_CHROMA_411: begin
        if (x[0] || s == 2'd1) pof_comp = COMP_Y;
        else pof_comp = x[1] ? COMP_CR : COMP_CB;
      end
      default: pof_comp = COMP_RAW;
    endcase
  endfunction : pof_comp

  // register state
  pof_fmt_t fmt_r;
  pof_depth_t depth_r;
  pof_phase_t phase_r;
  logic mirror_x_r;
  logic mirror_y_r;
  logic acq_en_r;
  logic pat_sel_r;
  pof_pat_t sens_pat_r;
  pof_pat_t head_pat_r;
  logic [15:0] width_r;
  logic [15:0] height_r;
  logic [7:0] frames_r;

  // bus data phase state
  logic a_wr_r;
  logic a_rd_r;
  logic [7:0] a_addr_r;

  // stream state
  pof_state_t state_r;
  logic [XW-1:0] wr_x_r;
  logic [YW-1:0] wr_y_r;
  logic [XW-1:0] rd_x_r;
  logic [YW-1:0] rd_y_r;
  logic [1:0] step_r;
  logic [7:0] inc_r;
  logic [7:0] seq_r;
  logic out_valid_r;
  pof_word_t out_word_r;
  pof_pix_t mem [NPIX];

  logic addr_ok;
  logic wr_data;
  logic acq_start;
  logic [15:0] w_eff;
  logic [15:0] h_eff;
  logic [XW-1:0] w_last;
  logic [YW-1:0] h_last;
  logic take;
  logic wr_last;
  logic load;
  logic [XW-1:0] src_x;
  logic [YW-1:0] src_y;
  pof_pix_t src;
  pof_pix_t wr_pix;
  logic [7:0] sens_grey;
  logic [7:0] head_grey;
  pof_comp_t comp;
  logic [1:0] nwords;
  logic last_step;
  logic line_end;
  logic frame_end;

  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_data = a_wr_r;
  assign acq_start = wr_data && a_addr_r == `POF_OFS_CTRL && hwdata[`POF_CTRL_ACQ_EN] && !acq_en_r;
  assign w_eff = pof_lim(width_r, XW);
  assign h_eff = pof_lim(height_r, YW);
  assign w_last = XW'(w_eff - 16'h0001);
  assign h_last = YW'(h_eff - 16'h0001);

  // bus answers at once with okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // capture the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_r <= 1'b0;
      a_rd_r <= 1'b0;
      a_addr_r <= 8'h00;
    end else begin
      a_wr_r <= addr_ok && hwrite;
      a_rd_r <= addr_ok && !hwrite;
      a_addr_r <= {haddr[7:2], 2'b00};
    end
  end

  // read mux in the data phase; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (a_rd_r) begin
      unique case (a_addr_r)
        `POF_OFS_CTRL: begin
          hrdata[`POF_CTRL_FMT_LSB +: 3] = fmt_r;
          hrdata[`POF_CTRL_DEPTH_LSB +: 2] = depth_r;
          hrdata[`POF_CTRL_MIRROR_X] = mirror_x_r;
          hrdata[`POF_CTRL_MIRROR_Y] = mirror_y_r;
          hrdata[`POF_CTRL_ACQ_EN] = acq_en_r;
          hrdata[`POF_CTRL_PHASE_LSB +: 2] = phase_r;
        end
        `POF_OFS_PATTERN: begin
          hrdata[`POF_PAT_SELECT] = pat_sel_r;
          hrdata[`POF_PAT_CHOICE_LSB +: 2] = pat_sel_r ? head_pat_r : sens_pat_r;
        end
        `POF_OFS_SIZE: hrdata = {height_r, width_r};
        `POF_OFS_STATUS: begin
          hrdata[`POF_STAT_PHASE_LSB +: 2] = mosaic_phase;
          hrdata[`POF_STAT_DRAIN] = state_r == S_DRAIN;
          hrdata[`POF_STAT_FRAMES_LSB +: 8] = frames_r;
        end
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // control register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_r <= FMT_RAW16;
      depth_r <= DEPTH_12;
      phase_r <= PH_MOSAIC_RED_GREEN;
      mirror_x_r <= 1'b0;
      mirror_y_r <= 1'b0;
      acq_en_r <= 1'b0;
    end else if (wr_data && a_addr_r == `POF_OFS_CTRL) begin
      fmt_r <= pof_fmt_t'(hwdata[`POF_CTRL_FMT_LSB +: 3]);
      if (!acq_en_r) depth_r <= pof_depth_t'(hwdata[`POF_CTRL_DEPTH_LSB +: 2]);
      mirror_x_r <= hwdata[`POF_CTRL_MIRROR_X];
      mirror_y_r <= hwdata[`POF_CTRL_MIRROR_Y];
      acq_en_r <= hwdata[`POF_CTRL_ACQ_EN];
      phase_r <= pof_phase_t'(hwdata[`POF_CTRL_PHASE_LSB +: 2]);
    end
  end

  // pattern register: only the addressed source changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pat_sel_r <= 1'b0;
      sens_pat_r <= PAT_OFF;
      head_pat_r <= PAT_OFF;
    end else if (wr_data && a_addr_r == `POF_OFS_PATTERN) begin
      pat_sel_r <= hwdata[`POF_PAT_SELECT];
      if (hwdata[`POF_PAT_SELECT]) head_pat_r <= pof_pat_t'(hwdata[`POF_PAT_CHOICE_LSB +: 2]);
      else sens_pat_r <= pof_pat_t'(hwdata[`POF_PAT_CHOICE_LSB +: 2]);
    end
  end

  // frame size register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      width_r <= `POF_RST_WIDTH;
      height_r <= `POF_RST_HEIGHT;
    end else if (wr_data && a_addr_r == `POF_OFS_SIZE) begin
      width_r <= hwdata[`POF_SIZE_W_LSB +: 16];
      height_r <= hwdata[`POF_SIZE_H_LSB +: 16];
    end
  end

  // mosaic phase relabelled by the mirrors
  assign mosaic_phase = pof_phase_t'(phase_r ^ {mirror_y_r, mirror_x_r});

  // the store fills while acquiring; back-pressure while it drains
  assign in_ready = acq_en_r && state_r != S_DRAIN;
  assign take = in_valid && in_ready && (state_r == S_FILL || in_pix.sof);
  assign wr_last = wr_x_r == w_last && wr_y_r == h_last;

  // pattern greys; sensor pattern stands in for the sensor image itself
  assign sens_grey = 8'(wr_x_r) ^ 8'(wr_y_r);
  assign head_grey = (head_pat_r == PAT_INCREMENT) ? inc_r : 8'(8'(wr_x_r) + 8'(wr_y_r) + seq_r);

  // pixel entering the head of the chain; head pattern wins over sensor pattern
  always_comb begin
    wr_pix = '{raw: pof_justify(in_pix.raw, depth_r), r: in_pix.r, g: in_pix.g, b: in_pix.b};
    if (sens_pat_r == PAT_SENSOR) begin
      wr_pix = '{raw: {sens_grey, 8'h00}, r: sens_grey, g: sens_grey, b: sens_grey};
    end
    if (head_pat_r == PAT_INCREMENT || head_pat_r == PAT_VARFRAME) begin
      wr_pix = '{raw: {head_grey, 8'h00}, r: head_grey, g: head_grey, b: head_grey};
    end
  end

  // frame store write
  always_ff @(posedge hclk) begin
    if (take) mem[{wr_y_r, wr_x_r}] <= wr_pix;
  end

  // increment pattern counts accepted pixels, wrapping after 255
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) inc_r <= 8'h00;
    else if (state_r == S_IDLE && !take) inc_r <= 8'h00;
    else if (take) inc_r <= inc_r + 8'h01;
  end

  // varying-frame sequence restarts at each acquisition start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) seq_r <= 8'h00;
    else if (acq_start) seq_r <= 8'h00;
    else if (frame_end) seq_r <= seq_r + 8'h01;
  end

  // mirrored source address; any crop would follow this step
  assign src_x = mirror_x_r ? XW'(w_last - rd_x_r) : rd_x_r;
  assign src_y = mirror_y_r ? YW'(h_last - rd_y_r) : rd_y_r;
  assign src = mem[{src_y, src_x}];

  // word sequencing for the current output pixel
  assign nwords = pof_words(fmt_r, rd_x_r[1:0]);
  assign comp = pof_comp(fmt_r, rd_x_r[1:0], step_r);
  assign last_step = step_r == nwords - 2'd1;
  assign line_end = last_step && rd_x_r == w_last;
  assign load = state_r == S_DRAIN && (!out_valid_r || out_ready);
  assign frame_end = load && line_end && rd_y_r == h_last;

  // stream state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_r <= S_IDLE;
    else begin
      unique case (state_r)
        S_IDLE: if (take) state_r <= wr_last ? S_DRAIN : S_FILL;
        S_FILL: if (take && wr_last) state_r <= S_DRAIN;
        S_DRAIN: if (frame_end) state_r <= S_IDLE;
      endcase
    end
  end

  // write position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_x_r <= '0;
      wr_y_r <= '0;
    end else if (take) begin
      if (wr_x_r == w_last) begin
        wr_x_r <= '0;
        wr_y_r <= wr_last ? '0 : wr_y_r + YW'(1);
      end else wr_x_r <= wr_x_r + XW'(1);
    end
  end

  // read position and word step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_x_r <= '0;
      rd_y_r <= '0;
      step_r <= 2'd0;
    end else if (load) begin
      if (!last_step) step_r <= step_r + 2'd1;
      else begin
        step_r <= 2'd0;
        if (rd_x_r == w_last) begin
          rd_x_r <= '0;
          rd_y_r <= (rd_y_r == h_last) ? '0 : rd_y_r + YW'(1);
        end else rd_x_r <= rd_x_r + XW'(1);
      end
    end
  end

  // output word register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid_r <= 1'b0;
      out_word_r <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_word_r.sof <= rd_x_r == '0 && rd_y_r == '0 && step_r == 2'd0;
      out_word_r.eol <= line_end;
      if (fmt_r == FMT_RAW16) out_word_r.data <= src.raw;
      else if (fmt_r == FMT_RAW8) out_word_r.data <= {src.raw[15:8], 8'h00};
      else out_word_r.data <= {pof_ycc(comp, src), 8'h00};
    end else if (out_ready) out_valid_r <= 1'b0;
  end

  // frames delivered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) frames_r <= 8'h00;
    else if (frame_end) frames_r <= frames_r + 8'h01;
  end

  assign out_valid = out_valid_r;
  assign out_word = out_word_r;

endmodule : pof_top

// ### testbench/pof_top_assertions.sv
// pixel output formatter checker: bus, stream and mosaic phase relations
// assumes binding into pof_top and the register map of pof_regs.svh
`timescale 1ns/1ps
`include "pof_regs.svh"
module pof_top_checker import pof_pkg::*; #(
  parameter int XW = 6, // log2 of largest line width
  parameter int YW = 5  // log2 of largest frame height
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic in_ready, // pixel accepted
  input wire logic out_valid, // word valid
  input wire logic out_ready, // sink ready
  input wire pof_word_t out_word, // outgoing word
  input wire pof_phase_t mosaic_phase // phase after mirroring
);
  logic ap_wr_r;
  logic ap_rd_r;
  logic [7:0] ap_a_r;
  logic [9:0] ctrl_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // remember the address phase for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_a_r <= 8'h00;
    end else if (hready) begin
      ap_wr_r <= hsel && htrans[1] && hwrite;
      ap_rd_r <= hsel && htrans[1] && !hwrite;
      ap_a_r <= haddr[7:0];
    end
  end
  // control shadow; depth held while acquiring
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 10'h009;
    end else if (ap_wr_r && ap_a_r == `POF_OFS_CTRL) begin
      ctrl_r <= ctrl_r[7] ? {hwdata[9:5], ctrl_r[4:3], hwdata[2:0]} : hwdata[9:0];
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  mosaic_phase_a: assert property (mosaic_phase == (ctrl_r[9:8] ^ ctrl_r[6:5]))
    else $error("mosaic phase wrong");
  acq_gate_a: assert property (in_ready |-> ctrl_r[7])
    else $error("pixel accepted while stopped");
  word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word changed while stalled");
  drain_block_a: assert property (out_valid && in_ready |-> out_word.eol)
    else $error("input open during drain");
  rdata_idle_a: assert property (!ap_rd_r |-> hrdata == 32'h0000_0000)
    else $error("read data outside read phase");
  ctrl_read_a: assert property (ap_rd_r && ap_a_r == `POF_OFS_CTRL |-> hrdata[9:0] == ctrl_r)
    else $error("control read back wrong");
  comp_pad_a: assert property (out_valid && ctrl_r[2:0] != 3'h1 |-> out_word.data[7:0] == 8'h00)
    else $error("8-bit word not left aligned");
  raw_pad_a: assert property (out_valid && ctrl_r[2:0] == 3'h1 |->
    (out_word.data << (10 + 2 * ctrl_r[4:3])) == 16'h0000)
    else $error("raw padding bits not zero");
  first_sof_a: assert property ($rose(out_valid) |-> out_word.sof)
    else $error("frame does not open with start mark");
endmodule : pof_top_checker

bind pof_top pof_top_checker #(.XW(XW), .YW(YW)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_word(out_word), .mosaic_phase(mosaic_phase));

// ### testbench/pof_sink.sv
// host side sink: takes output words, promptly or with random stalls
// assumes the same clock and reset as the formatter
`timescale 1ns/1ps
module pof_sink (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic slow, // stall at random when high
  output logic out_ready // word taken
);
  int seed = 76475;
  // ready changes only just after an edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= slow ? 1'($random(seed)) : 1'b1;
    end
  end
endmodule : pof_sink

// ### testbench/pof_top_tb_top.sv
// pixel output formatter bench: register setup, frames in, words checked in order
// assumes pof_top with its bound checker and the pof_sink partner
`timescale 1ns/1ps
`include "pof_regs.svh"
module pof_top_tb_top import pof_pkg::*; ;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, in_valid = 1'b0, slow = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, ctrl_last;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, in_ready, out_valid, out_ready;
  pof_in_t in_pix = '0;
  pof_word_t out_word, want, exp_q[$];
  pof_phase_t mosaic_phase;
  int seed = 76475, error_cnt = 0, n_checks = 0, cyc = 0;
  pof_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .mosaic_phase(mosaic_phase));
  pof_sink u_sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .out_ready(out_ready));
  // 250 MHz clock
  initial forever #2 hclk = ~hclk;
  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'($random(seed));
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, want);
  endtask : rdchk
  // luma or chroma of one pixel, clamped, left aligned
  function automatic logic [15:0] ycc(input logic [23:0] p, input int k);
    int r, g, b, t;
    r = int'(p[23:16]);
    g = int'(p[15:8]);
    b = int'(p[7:0]);
    case (k)
      0: t = (`POF_KY_R * r + `POF_KY_G * g + `POF_KY_B * b) >>> 8;
      1: t = ((`POF_KB_R * r + `POF_KB_G * g + `POF_KB_B * b) >>> 8) + 128;
      default: t = ((`POF_KR_R * r + `POF_KR_G * g + `POF_KR_B * b) >>> 8) + 128;
    endcase
    t = t < 0 ? 0 : t > 255 ? 255 : t;
    return {8'(t), 8'h00};
  endfunction : ycc
  // set up, send one frame, note the expected words, wait for the drain
  task automatic frame(input logic [2:0] fmt, input logic [1:0] dep, input logic mx, input logic my,
                       input int w, input int h, input int pat, input bit rs);
    logic [13:0] smp[$];
    logic [23:0] gv[$];
    logic [23:0] p;
    logic [15:0] raw;
    logic [15:0] wd[3];
    logic [7:0] v;
    int sx, sy, n;
    if (rs) begin
      ctrl_last = {22'h00_0000, 2'($random(seed)), 1'b0, my, mx, dep, fmt};
      bus(1'b1, `POF_OFS_CTRL, 32'h0000_0000);
      bus(1'b1, `POF_OFS_CTRL, ctrl_last);
      bus(1'b1, `POF_OFS_SIZE, {16'(h), 16'(w)});
      bus(1'b1, `POF_OFS_CTRL, ctrl_last | 32'h0000_0080);
    end
    @(negedge hclk);
    check(32'(mosaic_phase), 32'(ctrl_last[9:8] ^ ctrl_last[6:5]));
    @(posedge hclk);
    for (int y = 0; y < h; y++)
      for (int x = 0; x < w; x++) begin
        smp.push_back(14'($random(seed)) & ~(14'h3fff << (10 + 2 * dep)));
        p = 24'($random(seed));
        gv.push_back(p);
        in_valid <= 1'b1;
        in_pix <= '{sof: x == 0 && y == 0, raw: smp[$], r: p[23:16], g: p[15:8], b: p[7:0]};
        do @(posedge hclk); while (in_ready !== 1'b1);
      end
    in_valid <= 1'b0;
    for (int oy = 0; oy < h; oy++)
      for (int ox = 0; ox < w; ox++) begin
        sx = mx ? w - 1 - ox : ox;
        sy = my ? h - 1 - oy : oy;
        raw = {2'b00, smp[sy * w + sx]} << (6 - 2 * dep);
        v = pat == 1 ? 8'(sx ^ sy) : pat == 2 ? 8'(sy * w + sx) : 8'(sx + sy + pat - 3);
        p = pat != 0 ? {v, v, v} : gv[sy * w + sx];
        wd = '{ycc(p, 1), ycc(p, 0), ycc(p, 2)};
        n = fmt == 3'h2 ? 3 : fmt == 3'h3 || (fmt == 3'h4 && ox % 2 == 0) ? 2 : 1;
        if (fmt > 3'h2 && (fmt == 3'h3 ? ox % 2 == 1 : ox % 4 == 2)) wd[0] = wd[2];
        if (fmt == 3'h4 && ox % 2 == 1) wd[0] = wd[1];
        if (fmt < 3'h2) wd[0] = fmt == 3'h1 ? raw : {raw[15:8], 8'h00};
        for (int i = 0; i < n; i++)
          exp_q.push_back('{sof: ox == 0 && oy == 0 && i == 0, eol: ox == w - 1 && i == n - 1, data: wd[i]});
      end
    while (exp_q.size() != 0) @(posedge hclk);
  endtask : frame
  // compare each accepted word with the oldest note; cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end else if (hresetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      want = exp_q.size() != 0 ? exp_q.pop_front() : pof_word_t'(~out_word);
      check(32'(out_word.data), 32'(want.data));
      check(32'({out_word.sof, out_word.eol}), 32'({want.sof, want.eol}));
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`POF_OFS_CTRL, 32'h0000_0009);
    rdchk(`POF_OFS_SIZE, 32'h0000_0000);
    rdchk(`POF_OFS_PATTERN, 32'h0000_0000);
    rdchk(`POF_OFS_STATUS, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0000_0000);
    for (int d = 0; d < 3; d++) begin
      slow <= d[0];
      frame(3'h1, d[1:0], d[0], d[1], 5, 3, 0, 1'b1);
    end
    frame(3'h0, 2'h1, 1'b1, 1'b1, 4, 2, 0, 1'b1);
    for (int f = 2; f < 5; f++) frame(3'(f), 2'h1, f[0], f[1], 6, 2, 0, 1'b1);
    bus(1'b1, `POF_OFS_CTRL, (ctrl_last ^ 32'h0000_0018) | 32'h0000_0080);
    rdchk(`POF_OFS_CTRL, ctrl_last | 32'h0000_0080);
    rdchk(`POF_OFS_STATUS, {16'h0000, 8'h07, 6'h00, ctrl_last[9:8] ^ ctrl_last[6:5]});
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0002);
    rdchk(`POF_OFS_PATTERN, 32'h0000_0002);
    frame(3'h2, 2'h1, 1'b0, 1'b1, 4, 2, 1, 1'b1);
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0005);
    frame(3'h2, 2'h1, 1'b0, 1'b0, 20, 16, 2, 1'b1);
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0001);
    rdchk(`POF_OFS_PATTERN, 32'h0000_0001);
    frame(3'h2, 2'h1, 1'b1, 1'b0, 4, 2, 1, 1'b1);
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0007);
    frame(3'h2, 2'h1, 1'b0, 1'b0, 4, 2, 3, 1'b1);
    frame(3'h2, 2'h1, 1'b0, 1'b0, 4, 2, 4, 1'b0);
    frame(3'h2, 2'h1, 1'b0, 1'b0, 4, 2, 3, 1'b1);
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0001);
    bus(1'b1, `POF_OFS_PATTERN, 32'h0000_0000);
    frame(3'h2, 2'h1, 1'b0, 1'b0, 4, 2, 0, 1'b1);
    finish_test();
  end
endmodule : pof_top_tb_top
